// >>> design/dtp_consts.svh
/*
 constants for the debug, trace and test port: tap states are in the
 package; this header holds status codes and timing counts.
 assumes: included by bare name from design files only.
*/
`ifndef DTP_CONSTS_SVH
`define DTP_CONSTS_SVH

`define DTP_ST_HALTED 4'hf
`define DTP_ST_RST_C 4'hc
`define DTP_ST_RST_D 4'hd
`define DTP_ST_IDLE 4'h0
`define DTP_DS_WIDTH 8
`define DTP_FIFO_DEPTH 16
`define DTP_SCLK_DIV 5

`endif

// >>> design/dtp_pkg.sv
/*
 types for the debug, trace and test port.
 assumes: compiled before the design module.
*/
package dtp_pkg;
    typedef enum logic [3:0] {
        DTP_TLR, DTP_RTI, DTP_SEL_DR, DTP_CAP_DR, DTP_SH_DR, DTP_EX1_DR,
        DTP_PA_DR, DTP_EX2_DR, DTP_UPD_DR, DTP_SEL_IR, DTP_CAP_IR,
        DTP_SH_IR, DTP_EX1_IR, DTP_PA_IR, DTP_EX2_IR, DTP_UPD_IR
    } dtp_tap_t;
endpackage : dtp_pkg

// >>> design/dtp_fifo.sv
/*
 parameterised flip-flop fifo with valid/ready on both sides.
 assumes: single clock, asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two");
    end

    // honest full/empty from the fill count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rp_r];

    // storage write
    always_ff @(posedge clk_sys) begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    // pointers and count
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wp_r <= wp_r + 1'b1;
            if (pop)
                rp_r <= rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule : dtp_fifo
`default_nettype wire

// >>> design/dtp_top.sv
/*
 debug, trace and test port: test access port sampling its test clock on clk_sys, a serial
 debug port oversampled by clk_sys, halt handling and status/trace outputs.
 assumes: core supplies status, trace words and instruction-done strobes
 on clk_sys; the trace fifo is drained by the trace output pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dtp_consts.svh"
// Function
// - at reset release, strap selects serial debug or boundary-scan pins
// - test reset low asynchronously returns tap logic to its initial state
// - tap state machine advances on mode select captured at test clock rise
// - test data input captured at each test clock rising edge
// - test data output driven only in shift-ir or shift-dr
// - test data output updates on the test clock falling edge
// - serial clock level accepted after two equal bus-clock samples
// - validated serial clock rise samples input and changes output
// - serial input is synchronised and used only after clock seen high
// - serial output comes from a register, delayed from clock validation
// - halt request lets the current instruction finish, then halts
// - while halted, status and combined outputs show 0xf
// - with halt-as-interrupt set, halt request raises debug interrupt
// - status sample clock is a delayed copy centred in output window
// - trace-quiet freezes sample clock, status and trace; triggers stay
// - sample clock idle until first 0xc, 0xd or 0xf status in reset
// - all-ones output is the and of the four status bits
// - status outputs timed to the processor clock, independent of bus
// - trace nibbles timed for sampling on the system clock output
module dtp_top
    import dtp_pkg::*;
#(
    parameter int DS_WIDTH = `DTP_DS_WIDTH,
    parameter int FIFO_DEPTH = `DTP_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic test_sel_strap,
    input wire logic tap_rst_n,
    input wire logic tap_clk,
    input wire logic tap_mode,
    input wire logic tap_din,
    output logic tap_dout,
    output logic tap_dout_oe,
    input wire logic dbg_serial_clk,
    input wire logic dbg_serial_in,
    output logic dbg_serial_out,
    output logic [DS_WIDTH-1:0] ds_rx_word,
    output logic ds_rx_valid,
    input wire logic [DS_WIDTH-1:0] ds_tx_word,
    input wire logic manual_halt_req,
    input wire logic halt_as_interrupt,
    input wire logic trace_quiet,
    input wire logic insn_done,
    input wire logic halt_release,
    input wire logic [3:0] core_status_in,
    input wire logic [3:0] trace_in,
    input wire logic trace_in_valid,
    output logic trace_in_ready,
    output logic core_halted,
    output logic debug_irq,
    output logic [3:0] core_status_nibble,
    output logic [3:0] trace_data_nibble,
    output logic [7:0] combined_status_data,
    output logic status_all_ones,
    output logic status_sample_clk,
    output logic system_clk_out
);
    initial begin
        if (DS_WIDTH < 2 || DS_WIDTH > 32)
            $error("serial word width out of range");
    end

    // strap pin passes two flops, then is caught once after reset release
    logic [1:0] strap_s_r;
    logic [1:0] strap_age_r;
    logic jtag_sel_r;
    logic strap_done_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_s_r <= '0;
            strap_age_r <= '0;
            jtag_sel_r <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            strap_s_r <= {strap_s_r[0], test_sel_strap};
            strap_age_r <= {strap_age_r[0], 1'b1};
            if (strap_age_r[1] && !strap_done_r) begin
                jtag_sel_r <= strap_s_r[1];
                strap_done_r <= 1'b1;
            end
        end
    end

    // tap pins: test clock sampled by clk_sys, two flops each
    logic [1:0] tck_s_r, tms_s_r, tdi_s_r, trst_s_r;
    logic tck_d_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // test clock idles high: avoids a false rise after reset
            tck_s_r <= '1;
            tms_s_r <= '0;
            tdi_s_r <= '0;
            trst_s_r <= '0;
            tck_d_r <= 1'b1;
        end else begin
            tck_s_r <= {tck_s_r[0], tap_clk};
            tms_s_r <= {tms_s_r[0], tap_mode};
            tdi_s_r <= {tdi_s_r[0], tap_din};
            trst_s_r <= {trst_s_r[0], tap_rst_n};
            tck_d_r <= tck_s_r[1];
        end
    end
    logic tck_rise, tck_fall, tap_on;
    assign tap_on = jtag_sel_r && strap_done_r;
    assign tck_rise = tap_on && tck_s_r[1] && !tck_d_r;
    assign tck_fall = tap_on && !tck_s_r[1] && tck_d_r;

    // tap controller; test reset pin clears it without any clock edge
    dtp_tap_t tap_r;
    dtp_tap_t tap_nxt;
    logic tap_arst_n;
    assign tap_arst_n = rst_n && tap_rst_n;
    always_comb begin
        tap_nxt = tap_r;
        unique case (tap_r)
            DTP_TLR: tap_nxt = tms_s_r[1] ? DTP_TLR : DTP_RTI;
            DTP_RTI: tap_nxt = tms_s_r[1] ? DTP_SEL_DR : DTP_RTI;
            DTP_SEL_DR: tap_nxt = tms_s_r[1] ? DTP_SEL_IR : DTP_CAP_DR;
            DTP_CAP_DR: tap_nxt = tms_s_r[1] ? DTP_EX1_DR : DTP_SH_DR;
            DTP_SH_DR: tap_nxt = tms_s_r[1] ? DTP_EX1_DR : DTP_SH_DR;
            DTP_EX1_DR: tap_nxt = tms_s_r[1] ? DTP_UPD_DR : DTP_PA_DR;
            DTP_PA_DR: tap_nxt = tms_s_r[1] ? DTP_EX2_DR : DTP_PA_DR;
            DTP_EX2_DR: tap_nxt = tms_s_r[1] ? DTP_UPD_DR : DTP_SH_DR;
            DTP_UPD_DR: tap_nxt = tms_s_r[1] ? DTP_SEL_DR : DTP_RTI;
            DTP_SEL_IR: tap_nxt = tms_s_r[1] ? DTP_TLR : DTP_CAP_IR;
            DTP_CAP_IR: tap_nxt = tms_s_r[1] ? DTP_EX1_IR : DTP_SH_IR;
            DTP_SH_IR: tap_nxt = tms_s_r[1] ? DTP_EX1_IR : DTP_SH_IR;
            DTP_EX1_IR: tap_nxt = tms_s_r[1] ? DTP_UPD_IR : DTP_PA_IR;
            DTP_PA_IR: tap_nxt = tms_s_r[1] ? DTP_EX2_IR : DTP_PA_IR;
            DTP_EX2_IR: tap_nxt = tms_s_r[1] ? DTP_UPD_IR : DTP_SH_IR;
            DTP_UPD_IR: tap_nxt = tms_s_r[1] ? DTP_SEL_DR : DTP_RTI;
        endcase
    end
    // shift regs: ir is 4 bits, dr is a 1-bit bypass
    logic [3:0] ir_r;
    logic bypass_r;
    logic shifting;
    assign shifting = (tap_r == DTP_SH_IR) || (tap_r == DTP_SH_DR);
    always_ff @(posedge clk_sys or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            tap_r <= DTP_TLR;
            ir_r <= 4'h1;
            bypass_r <= 1'b0;
        end else if (!trst_s_r[1]) begin
            tap_r <= DTP_TLR; // held while the pin is low
            ir_r <= 4'h1;
            bypass_r <= 1'b0;
        end else if (tck_rise) begin
            tap_r <= tap_nxt;
            if (tap_r == DTP_CAP_IR)
                ir_r <= 4'h1;
            else if (tap_r == DTP_SH_IR)
                ir_r <= {tdi_s_r[1], ir_r[3:1]};
            if (tap_r == DTP_CAP_DR)
                bypass_r <= 1'b0;
            else if (tap_r == DTP_SH_DR)
                bypass_r <= tdi_s_r[1];
        end
    end
    // output changes only on test clock fall, enabled only while shifting
    always_ff @(posedge clk_sys or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            tap_dout <= 1'b0;
            tap_dout_oe <= 1'b0;
        end else if (tck_fall) begin
            tap_dout <= (tap_r == DTP_SH_IR) ? ir_r[0] : bypass_r;
            tap_dout_oe <= shifting;
        end
    end

    // serial debug: two flops, then a level is kept only if two agree
    logic [1:0] dsc_s_r, dsi_s_r;
    logic dsc_prev_r, dsc_lvl_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dsc_s_r <= '0;
            dsi_s_r <= '0;
            dsc_prev_r <= 1'b0;
            dsc_lvl_r <= 1'b0;
        end else begin
            dsc_s_r <= {dsc_s_r[0], dbg_serial_clk};
            dsi_s_r <= {dsi_s_r[0], dbg_serial_in};
            dsc_prev_r <= dsc_s_r[1];
            if (dsc_s_r[1] == dsc_prev_r)
                dsc_lvl_r <= dsc_s_r[1];
        end
    end
    logic ds_rise;
    assign ds_rise = !tap_on && strap_done_r && !dsc_lvl_r &&
                     dsc_s_r[1] && dsc_prev_r;
    // serial shifter: sample and change output on validated rise
    logic [DS_WIDTH-1:0] ds_sh_r, ds_tx_r;
    logic [$clog2(DS_WIDTH+1)-1:0] ds_cnt_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ds_sh_r <= '0;
            ds_tx_r <= '0;
            ds_cnt_r <= '0;
            dbg_serial_out <= 1'b0;
            ds_rx_word <= '0;
            ds_rx_valid <= 1'b0;
        end else begin
            ds_rx_valid <= 1'b0;
            if (ds_rise) begin
                ds_sh_r <= {ds_sh_r[DS_WIDTH-2:0], dsi_s_r[1]};
                dbg_serial_out <= ds_tx_r[DS_WIDTH-1];
                ds_tx_r <= {ds_tx_r[DS_WIDTH-2:0], 1'b0};
                if (ds_cnt_r == ($bits(ds_cnt_r))'(DS_WIDTH-1)) begin
                    ds_cnt_r <= '0;
                    ds_rx_word <= {ds_sh_r[DS_WIDTH-2:0], dsi_s_r[1]};
                    ds_rx_valid <= 1'b1;
                    ds_tx_r <= ds_tx_word; // next response word
                end else begin
                    ds_cnt_r <= ds_cnt_r + 1'b1;
                end
            end
        end
    end

    // halt request: synchronised, acted on at instruction boundary
    logic [1:0] bk_s_r;
    logic bk_pend_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bk_s_r <= '0;
            bk_pend_r <= 1'b0;
            core_halted <= 1'b0;
            debug_irq <= 1'b0;
        end else begin
            bk_s_r <= {bk_s_r[0], manual_halt_req};
            debug_irq <= 1'b0;
            if (bk_s_r[1])
                bk_pend_r <= 1'b1; // new request wins over the clear
            else if (insn_done)
                bk_pend_r <= 1'b0;
            if (bk_pend_r && insn_done) begin
                if (halt_as_interrupt)
                    debug_irq <= 1'b1;
                else
                    core_halted <= 1'b1;
            end else if (halt_release)
                core_halted <= 1'b0;
        end
    end

    // trace fifo, drained one word per status window
    logic tr_valid, tr_pop;
    logic [3:0] tr_word;
    dtp_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(trace_in_valid),
        .in_ready(trace_in_ready),
        .in_data(trace_in),
        .out_valid(tr_valid),
        .out_ready(tr_pop),
        .out_data(tr_word)
    );

    // processor clock divided from clk_sys; sample clock runs one clk_sys cycle behind
    logic [2:0] div_r;
    logic started_r;
    logic win_start;
    logic [3:0] st_eff;
    assign win_start = (div_r == 3'h0);
    assign st_eff = core_halted ? `DTP_ST_HALTED : core_status_in;
    assign tr_pop = win_start && !trace_quiet && started_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= '0;
            started_r <= 1'b0;
            system_clk_out <= 1'b0;
            status_sample_clk <= 1'b0;
        end else begin
            div_r <= (div_r == 3'(`DTP_SCLK_DIV - 1)) ? 3'h0 : div_r + 3'h1;
            system_clk_out <= (div_r < 3'h2);
            if (st_eff == `DTP_ST_RST_C || st_eff == `DTP_ST_RST_D ||
                st_eff == `DTP_ST_HALTED)
                started_r <= 1'b1;
            // rise in mid window; frozen while quiet
            if (started_r && !trace_quiet)
                status_sample_clk <= (div_r == 3'h1) || (div_r == 3'h2);
        end
    end

    // status and trace launched at each processor clock window start
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_status_nibble <= `DTP_ST_IDLE;
            trace_data_nibble <= '0;
        end else if (win_start && !trace_quiet) begin
            core_status_nibble <= st_eff;
            if (tr_pop)
                trace_data_nibble <= tr_valid ? tr_word : 4'h0;
        end
    end
    assign status_all_ones = &core_status_nibble;
    assign combined_status_data = {core_status_nibble, trace_data_nibble};

    a_dout_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !shifting && tck_fall |=> !tap_dout_oe)
        else $error("test output driven outside shift");
    a_dout_edge: assert property (@(posedge clk_sys) disable iff (!tap_arst_n)
        $changed(tap_dout_oe) |-> $past(tck_fall))
        else $error("test output changed off falling edge");
    a_halt_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_halted && win_start && !trace_quiet |=>
        core_status_nibble == 4'hf)
        else $error("halted status not shown");
    a_halt_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        bk_pend_r && insn_done && halt_as_interrupt |=> debug_irq)
        else $error("debug interrupt missing");
    a_halt_boundary: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(core_halted) |-> $past(insn_done))
        else $error("halt without instruction boundary");
    a_quiet_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trace_quiet ##1 trace_quiet |-> $stable(status_sample_clk) &&
        $stable(core_status_nibble))
        else $error("outputs toggled while quiet");
    a_sclk_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !started_r |=> !status_sample_clk)
        else $error("sample clock started early");
    a_all_ones: assert property (@(posedge clk_sys) disable iff (!rst_n)
        status_all_ones == (core_status_nibble == 4'hf))
        else $error("all-ones output wrong");
    a_ds_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(dsc_lvl_r) |-> $past(dsc_s_r[1]) == $past(dsc_prev_r))
        else $error("serial clock level accepted early");
    a_tap_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !trst_s_r[1] |=> tap_r == DTP_TLR)
        else $error("tap not reset");
endmodule : dtp_top
`default_nettype wire

// >>> tb/dtp_host_model.sv
/*
 development system and boundary-scan tester model: drives the test port
 and serial debug pins, samples test data out and serial data out.
 assumes: its tasks are called by the bench, one transfer at a time.
*/
`timescale 1ns/10ps
`default_nettype none
module dtp_host_model (
    input wire logic clk_sys,
    output logic tap_clk,
    output logic tap_mode,
    output logic tap_din,
    input wire logic tap_dout,
    input wire logic tap_dout_oe,
    output logic dbg_serial_clk,
    output logic dbg_serial_in,
    input wire logic dbg_serial_out
);
    logic tdo_line;
    logic tdo_seen;
    logic oe_seen;

    // tester side pulls test data out up while nobody drives it
    assign tdo_line = tap_dout_oe ? tap_dout : 1'b1;

    // clocks stand still between frames
    initial begin
        tap_clk = 1'b1;
        tap_mode = 1'b1;
        tap_din = 1'b0;
        dbg_serial_clk = 1'b0;
        dbg_serial_in = 1'b1;
        tdo_seen = 1'b0;
        oe_seen = 1'b0;
    end

    // one 64 ns test clock period; outputs taken just before the rise
    task automatic tcyc(input logic tms, input logic tdi);
        @(posedge clk_sys);
        tap_clk <= 1'b0;
        tap_mode <= tms;
        tap_din <= tdi;
        repeat (8) @(posedge clk_sys);
        tdo_seen = tdo_line;
        oe_seen = tap_dout_oe;
        tap_clk <= 1'b1;
        repeat (7) @(posedge clk_sys);
    endtask : tcyc

    // one word msb first at 100 ns a bit, a fifth of the sample clock;
    // glitch picks a bit whose low phase gets a one-cycle runt pulse
    task automatic ds_word(input logic [7:0] tx, input int glitch,
                           output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            dbg_serial_clk <= 1'b0;
            dbg_serial_in <= tx[i];
            repeat (5) @(posedge clk_sys);
            dbg_serial_clk <= (i == glitch);
            @(posedge clk_sys);
            dbg_serial_clk <= 1'b0;
            repeat (6) @(posedge clk_sys);
            dbg_serial_clk <= 1'b1;
            repeat (12) @(posedge clk_sys);
            rx[i] = dbg_serial_out;
        end
        @(posedge clk_sys);
        dbg_serial_clk <= 1'b0;
        dbg_serial_in <= ~dbg_serial_in; // released line shows the inverse
    endtask : ds_word
endmodule : dtp_host_model
`default_nettype wire

// >>> tb/debug_trace_and_test_port_tb_top.sv
/*
 self-checking bench for the debug, trace and test port.
 assumes: dtp_pkg, dtp_fifo, dtp_top and dtp_host_model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module debug_trace_and_test_port_tb_top;
    logic clk_sys, rst_n, test_sel_strap, tap_rst_n, tap_clk, tap_mode;
    logic tap_din, tap_dout, tap_dout_oe, dbg_serial_clk, dbg_serial_in;
    logic dbg_serial_out, ds_rx_valid, manual_halt_req, halt_as_interrupt;
    logic trace_quiet, insn_done, halt_release, trace_in_valid;
    logic trace_in_ready, core_halted, debug_irq, status_all_ones;
    logic status_sample_clk, system_clk_out;
    logic [7:0] ds_rx_word, ds_tx_word, combined_status_data;
    logic [3:0] core_status_in, trace_in, core_status_nibble;
    logic [3:0] trace_data_nibble;
    int err_total, tests_run, rx_count;
    // test port steps: {mode, data in, oe expected, tdo expected}
    localparam logic [3:0] TAB [24] = '{4'h0, 4'h8, 4'h8, 4'h0, 4'h4,
        4'h7, 4'h6, 4'h6, 4'he, 4'h8, 4'h0, 4'h8, 4'h0, 4'h4, 4'h2, 4'h6,
        4'hf, 4'h8, 4'h0, 4'h8, 4'h0, 4'h0, 4'h6, 4'h0};

    dtp_top u_dtp_top (.clk_sys, .rst_n, .test_sel_strap, .tap_rst_n,
        .tap_clk, .tap_mode, .tap_din, .tap_dout, .tap_dout_oe,
        .dbg_serial_clk, .dbg_serial_in, .dbg_serial_out, .ds_rx_word,
        .ds_rx_valid, .ds_tx_word, .manual_halt_req, .halt_as_interrupt,
        .trace_quiet, .insn_done, .halt_release, .core_status_in, .trace_in,
        .trace_in_valid, .trace_in_ready, .core_halted, .debug_irq,
        .core_status_nibble, .trace_data_nibble, .combined_status_data,
        .status_all_ones, .status_sample_clk, .system_clk_out);
    dtp_host_model u_dtp_host_model (.clk_sys, .tap_clk, .tap_mode,
        .tap_din, .tap_dout, .tap_dout_oe, .dbg_serial_clk, .dbg_serial_in,
        .dbg_serial_out);

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // decoded status outputs must agree with the nibble every cycle
    always @(negedge clk_sys) begin
        if (rst_n) begin
            chk("all_ones", {7'h0, &core_status_nibble},
                {7'h0, status_all_ones});
            chk("combined", {core_status_nibble, trace_data_nibble},
                combined_status_data);
        end
    end

    // received serial words
    always @(posedge clk_sys) begin
        if (ds_rx_valid === 1'b1)
            rx_count++;
    end

    // waits for a sample clock rise, bounded by 12 clk_sys cycles
    task automatic next_win(output logic [3:0] tr);
        logic prev;
        prev = status_sample_clk;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            if (status_sample_clk && !prev) begin
                tr = trace_data_nibble;
                return;
            end
            prev = status_sample_clk;
        end
        chk("sample_clk_rise", 8'h1, 8'h0);
        end_sim();
    endtask : next_win

    task automatic do_reset(input logic strap);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        tap_rst_n <= 1'b0;
        test_sel_strap <= strap;
        repeat (4) @(posedge clk_sys);
        chk("reset_outs", 8'h0, {core_status_nibble, trace_data_nibble});
        rst_n <= 1'b1;
        tap_rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask : do_reset

    task automatic s_status();
        logic [3:0] vals [4] = '{4'hc, 4'hd, 4'hf, 4'h5};
        logic [3:0] tr;
        logic prev;
        int rises;
        rises = 0;
        prev = 1'b0;
        repeat (30) begin
            @(negedge clk_sys);
            rises += (status_sample_clk && !prev);
            prev = status_sample_clk;
        end
        chk("idle_rises", 8'h0, 8'(rises));
        foreach (vals[i]) begin
            @(posedge clk_sys);
            core_status_in <= vals[i];
            next_win(tr);
            next_win(tr);
            chk("status", {4'h0, vals[i]}, {4'h0, core_status_nibble});
        end
    endtask : s_status

    task automatic s_halt();
        logic [3:0] tr;
        @(posedge clk_sys);
        core_status_in <= 4'h2;
        manual_halt_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk("halt_early", 8'h0, {7'h0, core_halted});
        insn_done <= 1'b1;
        @(posedge clk_sys);
        insn_done <= 1'b0;
        next_win(tr);
        next_win(tr);
        chk("halted", 8'h1, {7'h0, core_halted});
        chk("halt_code", 8'hff,
            {core_status_nibble, combined_status_data[7:4]});
        @(posedge clk_sys);
        manual_halt_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        halt_release <= 1'b1;
        @(posedge clk_sys);
        halt_release <= 1'b0;
        next_win(tr);
        next_win(tr);
        chk("released", 8'h02, {3'h0, core_halted, core_status_nibble});
    endtask : s_halt

    task automatic s_irq();
        int irqs;
        logic h;
        irqs = 0;
        h = 1'b0;
        @(posedge clk_sys);
        halt_as_interrupt <= 1'b1;
        manual_halt_req <= 1'b1;
        repeat (8) @(posedge clk_sys);
        insn_done <= 1'b1;
        @(posedge clk_sys);
        insn_done <= 1'b0;
        repeat (10) begin
            @(negedge clk_sys);
            irqs += (debug_irq === 1'b1);
            h |= core_halted;
        end
        chk("irq_pulses", 8'h1, 8'(irqs));
        chk("irq_no_halt", 8'h0, {7'h0, h});
        @(posedge clk_sys);
        manual_halt_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        halt_as_interrupt <= 1'b0;
    endtask : s_irq

    // quiet freezes outputs, fifo fills until refused, then drains
    task automatic s_quiet();
        logic [8:0] snap;
        logic [3:0] tr;
        int n;
        @(posedge clk_sys);
        trace_quiet <= 1'b1;
        repeat (10) @(posedge clk_sys);
        snap = {status_sample_clk, core_status_nibble, trace_data_nibble};
        core_status_in <= 4'h9;
        s_irq();
        chk("quiet_outs", snap[7:0],
            {core_status_nibble, trace_data_nibble});
        chk("quiet_clk", {7'h0, snap[8]}, {7'h0, status_sample_clk});
        trace_in_valid <= 1'b1;
        trace_in <= 4'h1;
        n = 0;
        for (int i = 0; i < 20; i++) begin
            @(negedge clk_sys);
            if (!trace_in_ready)
                break;
            @(posedge clk_sys);
            n++;
            trace_in <= 4'(n + 1);
        end
        chk("fifo_fill", 8'd16, 8'(n));
        @(posedge clk_sys);
        trace_in_valid <= 1'b0;
        trace_quiet <= 1'b0;
        tr = 4'h0;
        for (int i = 0; i < 8 && tr !== 4'h1; i++)
            next_win(tr);
        chk("trace_first", 8'h1, {4'h0, tr});
        for (int k = 1; k < 17; k++) begin
            next_win(tr);
            chk("trace_word", (k < 16) ? {4'h0, 4'(k + 1)} : 8'h0, {4'h0, tr});
        end
        chk("resumed", 8'h19, {3'h0, trace_in_ready, core_status_nibble});
    endtask : s_quiet

    task automatic s_serial(input logic on);
        logic [7:0] rx;
        rx_count = 0;
        u_dtp_host_model.ds_word(8'h3c, 2, rx);
        if (on) begin
            chk("ds_rx_word", 8'h3c, ds_rx_word);
            chk("ds_first_out", 8'h00, rx);
            u_dtp_host_model.ds_word(8'hc3, -1, rx);
            chk("ds_rx_word", 8'hc3, ds_rx_word);
            chk("ds_out", 8'ha5, rx);
        end
        chk("ds_words", on ? 8'h2 : 8'h0, 8'(rx_count));
    endtask : s_serial

    task automatic s_tap(input int n, input logic on);
        logic [1:0] e;
        for (int i = 0; i < n; i++) begin
            if (i == 23) begin
                @(posedge clk_sys);
                tap_rst_n <= 1'b0;
                repeat (3) @(posedge clk_sys);
                tap_rst_n <= 1'b1;
            end
            u_dtp_host_model.tcyc(TAB[i][3], TAB[i][2]);
            e = on ? TAB[i][1:0] : 2'b00;
            chk("tdo_oe", {7'h0, e[1]}, {7'h0, u_dtp_host_model.oe_seen});
            if (e[1])
                chk("tdo", {7'h0, e[0]}, {7'h0, u_dtp_host_model.tdo_seen});
        end
    endtask : s_tap

    // main sequence: serial debug mode first, then test port mode
    initial begin
        rst_n = 1'b0;
        test_sel_strap = 1'b0;
        tap_rst_n = 1'b0;
        ds_tx_word = 8'ha5;
        manual_halt_req = 1'b0;
        halt_as_interrupt = 1'b0;
        trace_quiet = 1'b0;
        insn_done = 1'b0;
        halt_release = 1'b0;
        core_status_in = 4'h3;
        trace_in = 4'h0;
        trace_in_valid = 1'b0;
        err_total = 0;
        tests_run = 0;
        rx_count = 0;
        do_reset(1'b0);
        s_status();
        s_halt();
        s_quiet();
        s_serial(1'b1);
        s_tap(6, 1'b0);
        do_reset(1'b1);
        s_tap(24, 1'b1);
        s_serial(1'b0);
        end_sim();
    end
endmodule : debug_trace_and_test_port_tb_top
`default_nettype wire
